// ---- hdl/fpp_phase_gen.sv ----
// Purpose: Splits the system clock into four repeating instruction phases
// Assumes: clk_src_sel_in is a static strap from a pin
// Notes:   Source choice is caught once after reset release
`timescale 1ns/1ps
`default_nettype none
module fpp_phase_gen
    import fpp_pkg::*;
(
    input  wire logic   sys_clk_in,
    input  wire logic   reset_in,
    input  wire logic [1:0] clk_src_sel_in,
    fpp_phase_if.gen    ph
);

    logic [1:0]      sel_meta_reg;
    logic [1:0]      sel_sync_reg;
    logic [1:0]      settle_reg;
    logic [1:0]      settle_next;
    logic            captured_reg;
    logic            captured_next;
    fpp_clk_src_type src_reg;
    fpp_clk_src_type src_next;
    fpp_phase_type   phase_reg;
    fpp_phase_type   phase_next;
    logic [3:0]      onehot_reg;
    logic [3:0]      onehot_next;

    // Phase order and strap capture
    always_comb begin
        unique case (phase_reg)
            PH_FETCH:  phase_next = PH_DECODE;
            PH_DECODE: phase_next = PH_ALU;
            PH_ALU:    phase_next = PH_WRITE;
            PH_WRITE:  phase_next = PH_FETCH;
        endcase
        onehot_next = 4'h1 << phase_idx(phase_next);
        settle_next = settle_reg;
        captured_next = captured_reg;
        src_next = src_reg;
        if (settle_reg != 2'(SYNC_SETTLE)) begin
            settle_next = 2'(settle_reg + 2'h1);
        end else if (!captured_reg) begin
            captured_next = 1'b1;
            // Reserved code falls back to the crystal
            src_next = (sel_sync_reg == 2'h3) ? SRC_CRYSTAL
                                              : fpp_clk_src_type'(sel_sync_reg);
        end
    end

    // Map a phase to its one-hot position
    function automatic logic [1:0] phase_idx(input fpp_phase_type p);
        unique case (p)
            PH_FETCH:  phase_idx = 2'h0;
            PH_DECODE: phase_idx = 2'h1;
            PH_ALU:    phase_idx = 2'h2;
            PH_WRITE:  phase_idx = 2'h3;
        endcase
    endfunction

    // Registers; strap passes two flops first
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sel_meta_reg <= 2'h0;
            sel_sync_reg <= 2'h0;
            settle_reg   <= 2'h0;
            captured_reg <= 1'b0;
            src_reg      <= SRC_CRYSTAL;
            phase_reg    <= PH_WRITE;
            onehot_reg   <= ONEHOT_RESET;
        end else begin
            sel_meta_reg <= clk_src_sel_in;
            sel_sync_reg <= sel_meta_reg;
            settle_reg   <= settle_next;
            captured_reg <= captured_next;
            src_reg      <= src_next;
            phase_reg    <= phase_next;
            onehot_reg   <= onehot_next;
        end
    end

    assign ph.phase        = phase_reg;
    assign ph.phase_onehot = onehot_reg;
    assign ph.clk_src      = src_reg;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_rest_of_cycle;
        (phase_reg == PH_DECODE) ##1 (phase_reg == PH_ALU) ##1 (phase_reg == PH_WRITE);
    endsequence
    property p_phase_order;
        (phase_reg == PH_FETCH) |=> s_rest_of_cycle ##1 (phase_reg == PH_FETCH);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken");
    property p_phase_onehot;
        $onehot(onehot_reg) && onehot_reg[phase_idx(phase_reg)];
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase overlap");
    property p_src_fixed;
        captured_reg |=> $stable(src_reg) && captured_reg;
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("clock source changed");

endmodule
`default_nettype wire

// ---- hdl/fpp_pipeline.sv ----
// Purpose: Fetch/execute sequencing core of a small 8-bit controller
// Assumes: Program memory returns data one cycle after prog_addr_out changes
// Notes:   Each instruction cycle spans four system clocks
// How it works
// - The system clock source is chosen once as crystal, external RC or internal RC.
// - The system clock is split into four non-overlapping phases in fixed order.
// - The program counter steps at the start of the fetch phase and a new fetch begins.
// - Decode and execution happen in the second, third and fourth phases.
// - One pass through the four phases is one instruction cycle.
// - Fetch of the next instruction overlaps execution, giving one instruction per cycle.
// - An instruction that changes the program counter costs one extra cycle.
// - A branch or call takes two cycles, one to get the target and one to transfer.
// - An 8-bit ALU does arithmetic, logic, rotate, increment and decrement; the skip test reads operand_reg directly.
// - Operands and results move through the accumulator and the ALU.
// - Special registers sit in data memory and are reached directly or indirectly.
// - The program counter advances by one unless a jump target is loaded.
// - A met skip condition discards the prefetched instruction for a dummy cycle.
`timescale 1ns/1ps
`default_nettype none
module fpp_pipeline
    import fpp_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_DEF
) (
    input  wire logic            sys_clk_in,
    input  wire logic            reset_in,
    input  wire logic [1:0]      clk_src_sel_in,
    input  wire logic [IR_W-1:0] prog_data_in,
    output logic      [3:0]      phase_out,
    output logic      [1:0]      clk_src_out,
    output logic      [PC_W-1:0] prog_addr_out,
    output logic      [DW-1:0]   acc_out,
    output logic      [DW-1:0]   status_out,
    output logic                 exec_valid_out
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    fpp_phase_if ph_if ();

    fpp_phase_gen u_phase_gen (
        .sys_clk_in     (sys_clk_in),
        .reset_in       (reset_in),
        .clk_src_sel_in (clk_src_sel_in),
        .ph             (ph_if.gen)
    );

    fpp_phase_type   ph;
    logic [PC_W-1:0] pc_reg,        pc_next;
    logic [PC_W-1:0] prog_addr_reg, prog_addr_next;
    logic [IR_W-1:0] exec_ir_reg,   exec_ir_next;
    logic            exec_valid_reg, exec_valid_next;
    logic            flush_reg,     flush_next;
    logic [SP_W-1:0] sp_reg,        sp_next;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic            push_en;
    logic [DW-1:0]   operand_reg,   operand_next;
    logic [DW-1:0]   alu_res_reg,   alu_res_next;
    logic            carry_reg,     carry_next;
    logic [DW-1:0]   acc_reg,       acc_next;
    logic [DW-1:0]   status_reg,    status_next;
    logic [DW-1:0]   dm_mem [2**DM_AW];
    logic            dm_we;
    logic [DM_AW-1:0] dm_ea;
    logic [DW-1:0]   rd_data;
    logic [DW-1:0]   ind_data;
    fpp_op_type      op;
    logic            is_branch;
    logic            is_alu;
    logic [DW:0]     alu_out;

    assign ph = ph_if.phase;

    // Indirect window resolves through the pointer register
    function automatic logic [DM_AW-1:0] eff_addr(input logic [DM_AW-1:0] a,
                                                  input logic [DW-1:0]    p);
        eff_addr = (a == DM_INDIRECT) ? p[DM_AW-1:0] : a;
    endfunction

    // Decode of the instruction in execution
    always_comb begin
        op        = fpp_op_type'(exec_ir_reg[OP_MSB:OP_LSB]);
        is_branch = exec_valid_reg && (op == OP_JMP || op == OP_CALL || op == OP_RET);
        is_alu    = (op >= OP_LDA) && (op <= OP_DEC) && (op != OP_STA);
        dm_ea     = eff_addr(exec_ir_reg[DM_AW-1:0], dm_mem[DM_POINTER]);
        ind_data  = dm_mem[eff_addr(DM_INDIRECT, dm_mem[DM_POINTER])];
        if (dm_ea == DM_STATUS) begin
            rd_data = status_reg;
        end else if (dm_ea == DM_PCL) begin
            rd_data = prog_addr_reg[DW-1:0];
        end else begin
            rd_data = dm_mem[dm_ea];
        end
    end

    // ALU, every op takes operand_reg; add, subtract and logic ops also take the accumulator
    // Carry in is the status bit, so a store to status reaches the ALU
    always_comb begin
        unique case (op)
            OP_ADD:  alu_out = {1'b0, acc_reg} + {1'b0, operand_reg};
            OP_SUB:  alu_out = {1'b0, acc_reg} - {1'b0, operand_reg};
            OP_AND:  alu_out = {status_reg[STAT_CARRY_BIT], acc_reg & operand_reg};
            OP_OR:   alu_out = {status_reg[STAT_CARRY_BIT], acc_reg | operand_reg};
            OP_XOR:  alu_out = {status_reg[STAT_CARRY_BIT], acc_reg ^ operand_reg};
            OP_RRC:  alu_out = {operand_reg[0], status_reg[STAT_CARRY_BIT],
                                operand_reg[DW-1:1]};
            OP_INC:  alu_out = {1'b0, operand_reg} + 9'h001;
            OP_DEC:  alu_out = {1'b0, operand_reg} - 9'h001;
            default: alu_out = {status_reg[STAT_CARRY_BIT], operand_reg};
        endcase
    end

    // Sequencing: program counter, prefetch, flush and call stack
    always_comb begin
        pc_next         = pc_reg;
        prog_addr_next  = prog_addr_reg;
        exec_ir_next    = exec_ir_reg;
        exec_valid_next = exec_valid_reg;
        flush_next      = flush_reg;
        sp_next         = sp_reg;
        push_en         = 1'b0;
        unique case (ph)
            PH_ALU: begin
                // Branch decision in the third phase keeps the target ready for fetch
                if (is_branch) begin
                    flush_next = 1'b1;
                    if (op == OP_RET) begin
                        sp_next = SP_W'(sp_reg - 1'b1);
                        pc_next = stack_mem[SP_W'(sp_reg - 1'b1)];
                    end else begin
                        pc_next = exec_ir_reg[PC_W-1:0];
                    end
                    if (op == OP_CALL) begin
                        push_en = 1'b1;
                        sp_next = SP_W'(sp_reg + 1'b1);
                    end
                end else if (exec_valid_reg && op == OP_SKZ && operand_reg == '0) begin
                    flush_next = 1'b1;
                end
            end
            PH_WRITE: begin
                prog_addr_next  = pc_reg;
                pc_next         = PC_W'(pc_reg + 1'b1);
                exec_ir_next    = prog_data_in;
                exec_valid_next = !flush_reg;
                flush_next      = 1'b0;
            end
            default: begin
            end
        endcase
    end

    // Datapath: operand read, ALU result, accumulator writeback
    always_comb begin
        operand_next = operand_reg;
        alu_res_next = alu_res_reg;
        carry_next   = carry_reg;
        acc_next     = acc_reg;
        status_next  = status_reg;
        dm_we        = 1'b0;
        unique case (ph)
            PH_DECODE: operand_next = rd_data;
            PH_ALU: begin
                alu_res_next = alu_out[DW-1:0];
                carry_next   = alu_out[DW];
            end
            PH_WRITE: begin
                if (exec_valid_reg) begin
                    if (op == OP_LDI) begin
                        acc_next = exec_ir_reg[DW-1:0];
                    end else if (is_alu) begin
                        acc_next = alu_res_reg;
                        status_next[STAT_ZERO_BIT]  = (alu_res_reg == '0);
                        status_next[STAT_CARRY_BIT] = carry_reg;
                    end else if (op == OP_STA) begin
                        // Status takes the accumulator, counter low byte is read only
                        if (dm_ea == DM_STATUS) begin
                            status_next = acc_reg;
                        end else if (dm_ea != DM_PCL) begin
                            dm_we = 1'b1;
                        end
                    end
                end
            end
            default: begin
            end
        endcase
    end

    // Control and datapath registers
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pc_reg         <= PC_RESET;
            prog_addr_reg  <= PC_RESET;
            exec_ir_reg    <= IR_RESET;
            exec_valid_reg <= 1'b0;
            flush_reg      <= 1'b1; // First latch after reset is stale, so it is flushed
            sp_reg         <= '0;
            operand_reg    <= '0;
            alu_res_reg    <= '0;
            carry_reg      <= 1'b0;
            acc_reg        <= ACC_RESET;
            status_reg     <= STATUS_RESET;
        end else begin
            pc_reg         <= pc_next;
            prog_addr_reg  <= prog_addr_next;
            exec_ir_reg    <= exec_ir_next;
            exec_valid_reg <= exec_valid_next;
            flush_reg      <= flush_next;
            sp_reg         <= sp_next;
            operand_reg    <= operand_next;
            alu_res_reg    <= alu_res_next;
            carry_reg      <= carry_next;
            acc_reg        <= acc_next;
            status_reg     <= status_next;
        end
    end

    // Memories hold no reset, like the real arrays; return address is the flushed slot
    always_ff @(posedge sys_clk_in) begin
        if (push_en) begin
            stack_mem[sp_reg] <= prog_addr_reg;
        end
        if (dm_we) begin
            dm_mem[dm_ea] <= acc_reg;
        end
    end

    assign phase_out      = ph_if.phase_onehot;
    assign clk_src_out    = ph_if.clk_src;
    assign prog_addr_out  = prog_addr_reg;
    assign acc_out        = acc_reg;
    assign status_out     = status_reg;
    assign exec_valid_out = exec_valid_reg;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_dummy_cycle;
        exec_valid_reg ##1 (!exec_valid_reg)[*4] ##1 exec_valid_reg;
    endsequence
    property p_pc_step;
        (ph == PH_WRITE) |=> (prog_addr_reg == $past(pc_reg))
                             && (pc_reg == PC_W'($past(pc_reg) + 1'b1));
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step at fetch");
    property p_branch_flush;
        (ph == PH_ALU && is_branch && op != OP_RET)
            |=> (pc_reg == $past(exec_ir_reg[PC_W-1:0])) and s_dummy_cycle;
    endproperty
    a_branch_flush: assert property (p_branch_flush) else $error("branch not flushed");
    property p_skip_flush;
        (ph == PH_ALU && exec_valid_reg && op == OP_SKZ && operand_reg == '0)
            |=> s_dummy_cycle;
    endproperty
    a_skip_flush: assert property (p_skip_flush) else $error("skip not flushed");
    property p_throughput;
        (ph == PH_WRITE && !flush_reg) |=> exec_valid_reg;
    endproperty
    a_throughput: assert property (p_throughput) else $error("bubble without flush");
    property p_add;
        (ph == PH_ALU && exec_valid_reg && op == OP_ADD)
            |=> ##1 (acc_reg == DW'($past(acc_reg, 2) + $past(operand_reg, 2)));
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    property p_ldi;
        (ph == PH_WRITE && exec_valid_reg && op == OP_LDI)
            |=> (acc_reg == $past(exec_ir_reg[DW-1:0]));
    endproperty
    a_ldi: assert property (p_ldi) else $error("immediate not in accumulator");
    property p_acc_late;
        $changed(acc_reg) |-> ($past(ph) == PH_WRITE);
    endproperty
    a_acc_late: assert property (p_acc_late) else $error("result outside write phase");
    property p_indirect;
        (ph == PH_DECODE && exec_ir_reg[DM_AW-1:0] == DM_INDIRECT
            && dm_mem[DM_POINTER][DM_AW-1:0] > DM_PCL)
            |=> (operand_reg == $past(ind_data));
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect read wrong");

endmodule
`default_nettype wire

// ---- include/fpp_phase_if.sv ----
// Purpose: Carries phase and clock source state from the phase generator
// Assumes: Single clock domain
// Notes:   All signals come from flip-flops in the generator
`timescale 1ns/1ps
`default_nettype none
interface fpp_phase_if;
    import fpp_pkg::*;
    fpp_phase_type   phase;
    logic [3:0]      phase_onehot;
    fpp_clk_src_type clk_src;
    modport gen  (output phase, output phase_onehot, output clk_src);
    modport core (input phase, input phase_onehot, input clk_src);
endinterface
`default_nettype wire

// ---- include/fpp_pkg.sv ----
// Purpose: Shared constants and types for the four-phase fetch/execute pipeline
// Assumes: One system clock; program memory answers one cycle after an address
// Notes:   Phase codes are Gray along fetch, decode, ALU, write
package fpp_pkg;

    // Datapath and memory widths
    localparam int IR_W         = 16;
    localparam int PC_W         = 11;
    localparam int DW           = 8;
    localparam int DM_AW        = 6;
    localparam int STACK_DEF    = 8;
    localparam int OP_MSB       = 15;
    localparam int OP_LSB       = 12;
    localparam int SYNC_SETTLE  = 2;

    // Special registers living in data memory
    localparam logic [DM_AW-1:0] DM_INDIRECT = 6'h00;
    localparam logic [DM_AW-1:0] DM_POINTER  = 6'h01;
    localparam logic [DM_AW-1:0] DM_STATUS   = 6'h02;
    localparam logic [DM_AW-1:0] DM_PCL      = 6'h03;

    // Status fields and reset values
    localparam int               STAT_ZERO_BIT  = 0;
    localparam int               STAT_CARRY_BIT = 1;
    localparam logic [DW-1:0]    STATUS_RESET   = 8'h00;
    localparam logic [DW-1:0]    ACC_RESET      = 8'h00;
    localparam logic [PC_W-1:0]  PC_RESET       = 11'h000;
    localparam logic [IR_W-1:0]  IR_RESET       = 16'h0000;
    localparam logic [3:0]       ONEHOT_RESET   = 4'h8;

    // Instruction phase clocks
    typedef enum logic [1:0] {
        PH_FETCH  = 2'h0,
        PH_DECODE = 2'h1,
        PH_ALU    = 2'h3,
        PH_WRITE  = 2'h2
    } fpp_phase_type;

    // System clock source selection
    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'h0,
        SRC_EXT_RC  = 2'h1,
        SRC_INT_RC  = 2'h2
    } fpp_clk_src_type;

    // Instruction opcodes, field [15:12]
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_LDI  = 4'h1,
        OP_LDA  = 4'h2,
        OP_STA  = 4'h3,
        OP_ADD  = 4'h4,
        OP_SUB  = 4'h5,
        OP_AND  = 4'h6,
        OP_OR   = 4'h7,
        OP_XOR  = 4'h8,
        OP_RRC  = 4'h9,
        OP_INC  = 4'ha,
        OP_DEC  = 4'hb,
        OP_SKZ  = 4'hc,
        OP_JMP  = 4'hd,
        OP_CALL = 4'he,
        OP_RET  = 4'hf
    } fpp_op_type;

endpackage

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the four-phase fetch/execute pipeline
// Assumes: Program memory is an array read at every falling edge
// Notes:   Each instruction cycle is stepped as four clocks, fetch to fetch
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fpp_pkg::*;

    typedef struct packed {
        logic [IR_W-1:0] word;
        logic [DW-1:0]   acc;
        logic [DW-1:0]   stat;
    } fpp_row_type;

    logic            sys_clk_in;
    logic            reset_in;
    logic [1:0]      clk_src_sel_in;
    logic [IR_W-1:0] prog_data_in;
    logic [3:0]      phase_out;
    logic [1:0]      clk_src_out;
    logic [PC_W-1:0] prog_addr_out;
    logic [DW-1:0]   acc_out;
    logic [DW-1:0]   status_out;
    logic            exec_valid_out;
    logic [IR_W-1:0] rom [0:2047];
    fpp_row_type     rows [0:19];
    int              miscompares;
    int              check_count;

    fpp_pipeline #(.STACK_DEPTH(STACK_DEF)) uut (
        .sys_clk_in     (sys_clk_in),
        .reset_in       (reset_in),
        .clk_src_sel_in (clk_src_sel_in),
        .prog_data_in   (prog_data_in),
        .phase_out      (phase_out),
        .clk_src_out    (clk_src_out),
        .prog_addr_out  (prog_addr_out),
        .acc_out        (acc_out),
        .status_out     (status_out),
        .exec_valid_out (exec_valid_out)
    );

    // Clock, 40 ns period
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Program memory, read off the sampling edge so data is settled early
    always @(negedge sys_clk_in) begin
        prog_data_in <= rom[prog_addr_out];
    end

    function automatic logic [IR_W-1:0] ins(input fpp_op_type op, input logic [11:0] arg);
        return {op, arg};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One instruction cycle; entered and left at the fetch phase
    task automatic step(input logic [PC_W-1:0] addr, input logic vld,
                        input logic [DW-1:0] acc, input logic [DW-1:0] st);
        chk(16'(prog_addr_out), 16'(addr));
        chk(16'(exec_valid_out), 16'(vld));
        chk(16'(acc_out), 16'(acc));
        chk(16'(status_out), 16'(st));
        for (int k = 0; k < 4; k++) begin
            chk(16'(phase_out), 16'(4'h1 << k));
            @(negedge sys_clk_in);
        end
    endtask

    // Reset values are checked while reset is held
    task automatic do_reset(input logic [1:0] sel);
        reset_in       = 1'b1;
        clk_src_sel_in = sel;
        repeat (2) @(negedge sys_clk_in);
        chk(16'(phase_out), 16'(ONEHOT_RESET));
        chk(16'(prog_addr_out), 16'(PC_RESET));
        chk(16'(acc_out), 16'(ACC_RESET));
        chk(16'(status_out), 16'(STATUS_RESET));
        chk(16'(exec_valid_out), 16'h0000);
        chk(16'(clk_src_out), 16'h0000);
        reset_in = 1'b0;
        @(negedge sys_clk_in);
    endtask

    // Watchdog; a hang counts as a mismatch
    initial begin
        #400000;
        miscompares++;
        $display("test run cut short by watchdog");
        wrap_up();
    end

    // Main sequence
    initial begin
        logic [DW-1:0] pa;
        logic [DW-1:0] ps;
        reset_in       = 1'b1;
        clk_src_sel_in = 2'h1;
        miscompares    = 0;
        check_count    = 0;
        pa             = ACC_RESET;
        ps             = STATUS_RESET;
        for (int a = 0; a < 2048; a++) begin
            rom[a] = 16'h0000;
        end
        rows[0]  = '{ins(OP_LDI, 12'h05a), 8'h5a, 8'h00};
        rows[1]  = '{ins(OP_STA, 12'h010), 8'h5a, 8'h00};
        rows[2]  = '{ins(OP_LDI, 12'h0ff), 8'hff, 8'h00};
        rows[3]  = '{ins(OP_ADD, 12'h010), 8'h59, 8'h02};
        rows[4]  = '{ins(OP_AND, 12'h010), 8'h58, 8'h02};
        rows[5]  = '{ins(OP_XOR, 12'h010), 8'h02, 8'h02};
        rows[6]  = '{ins(OP_OR,  12'h010), 8'h5a, 8'h02};
        rows[7]  = '{ins(OP_RRC, 12'h010), 8'had, 8'h00};
        rows[8]  = '{ins(OP_SUB, 12'h010), 8'h53, 8'h00};
        rows[9]  = '{ins(OP_LDA, 12'h010), 8'h5a, 8'h00};
        rows[10] = '{ins(OP_INC, 12'h010), 8'h5b, 8'h00};
        rows[11] = '{ins(OP_DEC, 12'h010), 8'h59, 8'h00};
        rows[12] = '{ins(OP_LDI, 12'h000), 8'h00, 8'h00};
        rows[13] = '{ins(OP_STA, 12'h011), 8'h00, 8'h00};
        rows[14] = '{ins(OP_SUB, 12'h010), 8'ha6, 8'h02};
        rows[15] = '{ins(OP_LDA, 12'h011), 8'h00, 8'h03};
        rows[16] = '{ins(OP_STA, 12'h002), 8'h00, 8'h00};
        rows[17] = '{ins(OP_LDI, 12'h010), 8'h10, 8'h00};
        rows[18] = '{ins(OP_STA, 12'h001), 8'h10, 8'h00};
        rows[19] = '{ins(OP_LDA, 12'h000), 8'h5a, 8'h00};
        for (int a = 0; a < 20; a++) begin
            rom[a] = rows[a].word;
        end
        // Branch program: skip, jump, call and return
        rom[20]     = ins(OP_SKZ, 12'h011);
        rom[21]     = ins(OP_LDI, 12'h0ee);
        rom[22]     = ins(OP_LDI, 12'h033);
        rom[23]     = ins(OP_JMP, 12'h040);
        rom[24]     = ins(OP_LDI, 12'h0ee);
        rom[11'h40] = ins(OP_CALL, 12'h050);
        rom[11'h41] = ins(OP_LDI, 12'h077);
        rom[11'h42] = ins(OP_SKZ, 12'h010);
        rom[11'h43] = ins(OP_LDI, 12'h088);
        rom[11'h50] = ins(OP_LDI, 12'h044);
        rom[11'h51] = ins(OP_RET, 12'h000);
        rom[11'h44] = ins(OP_LDA, 12'h003);
        rom[11'h45] = ins(OP_LDA, 12'h002);

        do_reset(2'h1);
        chk(16'(phase_out), 16'h0001);
        step(PC_RESET, 1'b0, ACC_RESET, STATUS_RESET);
        // Ordinary instructions, one per cycle
        for (int i = 0; i < 20; i++) begin
            step(PC_W'(i + 1), 1'b1, pa, ps);
            pa = rows[i].acc;
            ps = rows[i].stat;
        end
        chk(16'(clk_src_out), 16'h0001);
        $display("test table done");

        // Skip taken, then jump, call and return with flushed cycles
        step(11'd21, 1'b1, 8'h5a, 8'h00);
        step(11'd22, 1'b0, 8'h5a, 8'h00);
        step(11'd23, 1'b1, 8'h5a, 8'h00);
        step(11'd24, 1'b1, 8'h33, 8'h00);
        step(11'h040, 1'b0, 8'h33, 8'h00);
        step(11'h041, 1'b1, 8'h33, 8'h00);
        step(11'h050, 1'b0, 8'h33, 8'h00);
        step(11'h051, 1'b1, 8'h33, 8'h00);
        step(11'h052, 1'b1, 8'h44, 8'h00);
        step(11'h041, 1'b0, 8'h44, 8'h00);
        step(11'h042, 1'b1, 8'h44, 8'h00);
        step(11'h043, 1'b1, 8'h77, 8'h00);
        step(11'h044, 1'b1, 8'h77, 8'h00);
        step(11'h045, 1'b1, 8'h88, 8'h00);
        step(11'h046, 1'b1, 8'h45, 8'h00);
        step(11'h047, 1'b1, 8'h00, 8'h01);
        $display("test branches done");

        // Mid-run resets, every strap code, capture then hold
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            step(PC_RESET, 1'b0, ACC_RESET, STATUS_RESET);
            chk(16'(clk_src_out), (s == 3) ? 16'h0000 : 16'(s));
            clk_src_sel_in = ~2'(s);
            step(11'h001, 1'b1, ACC_RESET, STATUS_RESET);
            chk(16'(clk_src_out), (s == 3) ? 16'h0000 : 16'(s));
        end
        $display("test clock source done");
        wrap_up();
    end
endmodule
`default_nettype wire
